/* File: hdl/nvmcd_pkg.sv */
// Constants and types for the nonvolatile clock divider and EEPROM paging block
package nvmcd_pkg;

  // APB register byte offsets
  localparam logic [11:0] OFF_CLKDIV = 12'h000;
  localparam logic [11:0] OFF_CONFIG = 12'h004;
  localparam logic [11:0] OFF_OPTIONS = 12'h008;
  localparam logic [11:0] OFF_COMMAND = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [11:0] OFF_WIN_BASE = 12'h100;
  localparam logic [11:0] OFF_WIN_LAST = 12'h17C;

  // EEPROM geometry: 64 bytes physical, 32 visible
  localparam int PHYS_W = 6;
  localparam int FG_W = 5;
  localparam int EE_BYTES = 64;
  localparam int SECTOR_BYTES = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Clock divider register fields
  localparam int CD_LOAD_BIT = 7;
  localparam int CD_PRESCALE_BIT = 6;
  localparam int CD_RATIO_MSB = 5;
  localparam logic [6:0] CD_RESET = 7'h00;

  // Config, options and status fields
  localparam int CFG_PAGE_BIT = 6;
  localparam int OPT_SECTOR_BIT = 5;
  localparam logic [7:0] OPT_RESET = 8'h00;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_LOAD_BIT = 7;

  // Command register fields
  localparam int CMD_DATA_MSB = 7;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_ADDR_MSB = 12;
  localparam int CMD_OP_LSB = 16;
  localparam int CMD_OP_MSB = 17;
  localparam logic [1:0] OP_PROGRAM = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;

  // Timing pulses per operation and prescaler
  localparam logic [3:0] PROGRAM_PULSES = 4'h2;
  localparam logic [3:0] ERASE_PULSES = 4'h4;
  localparam logic [2:0] PRESCALE_LAST = 3'h7;

  typedef enum logic [1:0] {
    NVMCD_IDLE = 2'b00,
    NVMCD_RUN = 2'b01,
    NVMCD_COMMIT = 2'b10
  } nvmcd_state_type;

endpackage

/* File: hdl/nvmcd_clk_if.sv */
// Link between the controller and the timing clock divider
`timescale 1ns/1ps
interface nvmcd_clk_if;
  logic prescale_by_eight;
  logic [5:0] ratio;
  logic run;
  logic tick;
  modport ctrl (output prescale_by_eight, output ratio, output run, input tick);
  modport div (input prescale_by_eight, input ratio, input run, output tick);
endinterface

/* File: hdl/nvmcd_fclk_div.sv */
// Program/erase timing clock divider
`timescale 1ns/1ps
module nvmcd_fclk_div
  import nvmcd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Controller link
  nvmcd_clk_if.div link
);

  logic [2:0] pre_cnt_reg;
  logic [5:0] div_cnt_reg;
  logic tick_reg;
  logic pre_tick;

  // Bus clock or bus clock over eight feeds the ratio counter
  assign pre_tick = link.prescale_by_eight ? (pre_cnt_reg == PRESCALE_LAST) : 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_reg <= 3'h0;
    end else if (!link.run) begin
      pre_cnt_reg <= 3'h0;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 3'h1;
    end
  end

  // Stopped between operations so every run starts on a whole pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
    end else if (!link.run) begin
      div_cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
    end else if (pre_tick) begin
      if (div_cnt_reg == link.ratio) begin
        div_cnt_reg <= 6'h00;
        tick_reg <= 1'b1;
      end else begin
        div_cnt_reg <= div_cnt_reg + 6'h01;
        tick_reg <= 1'b0;
      end
    end else begin
      tick_reg <= 1'b0;
    end
  end

  assign link.tick = tick_reg;

endmodule

/* File: hdl/nvmcd_top.sv */
// APB register block with write-once clock divider and paged EEPROM
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps

// Functional notes
// - Only the foreground EEPROM half is reachable; background half is hidden.
// - Sector mapping is 4-byte or 8-byte, chosen by the options sector bit.
// - Sector mode 0 splits each sector four bytes per page, same addresses.
// - In 4-byte mode a sector erase clears all eight bytes, both pages.
// - Sector mode 1 keeps whole sectors in one page; page select hides others.
// - In 8-byte mode erase clears only the addressed foreground sector.
// - Divider bit 7 is read-only load flag; first write after reset sets it.
// - Divider bits 6:0 readable always, writable once per reset.
// - Erase and program are blocked until the load flag is set.
// - Prescale bit 6 feeds bus clock or bus clock divided by eight.
// - Memory clock is divider input over ratio field plus one.
// - Pulses last one memory clock; operations use whole pulse counts.
// - Options register loads from the option image once, at the first edge after reset release.
// - Config bit 6 page select: 0 shows page 0, 1 shows page 1.
// - Options bit 5 sector mode: 0 splits sectors, 1 keeps them whole.
module nvmcd_top
  import nvmcd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Nonvolatile option image, static from the array
  input wire logic [7:0] nv_option_image,
  // Status to the rest of the controller
  output logic prog_erase_enable,
  output logic nvm_busy
);

  nvmcd_clk_if clk_link ();

  nvmcd_fclk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .link(clk_link)
  );

  // Register state
  logic load_done_flag;
  logic [6:0] nvm_clock_divider_reg;
  logic eeprom_page_select;
  logic [7:0] nvm_options_reg;
  logic options_captured_reg;
  logic err_reg;
  logic busy_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  nvmcd_state_type state_reg;
  nvmcd_state_type state_next;
  logic [1:0] op_reg;
  logic [PHYS_W-1:0] op_addr_reg;
  logic [7:0] op_data_reg;
  logic [3:0] pulse_cnt_reg;
  logic [3:0] pulse_target;
  logic [7:0] ee_mem [EE_BYTES];

  // Decode
  logic eeprom_sector_mode;
  logic setup_phase;
  logic wr_take;
  logic in_window;
  logic [FG_W-1:0] win_addr;
  logic [PHYS_W-1:0] win_phys;
  logic [PHYS_W-1:0] cmd_phys;
  logic cmd_write;
  logic cmd_ok;
  logic cmd_refused;
  logic [1:0] cmd_op;
  logic [FG_W-1:0] cmd_addr;
  logic wr_clkdiv;
  logic wr_config;
  logic wr_status;
  logic [31:0] rd_word;
  logic rd_err;
  logic [EE_BYTES-1:0] erase_hit;

  assign eeprom_sector_mode = nvm_options_reg[OPT_SECTOR_BIT];
  assign setup_phase = psel & ~penable;
  assign wr_take = psel & penable & pready_reg & pwrite;
  assign in_window = (paddr >= OFF_WIN_BASE) && (paddr <= OFF_WIN_LAST) && (paddr[1:0] == 2'h0);
  assign win_addr = paddr[FG_W+1:2];

  // One strobe per writable register, all taken at the access edge
  assign wr_clkdiv = wr_take && (paddr == OFF_CLKDIV);
  assign wr_config = wr_take && (paddr == OFF_CONFIG);
  assign wr_status = wr_take && (paddr == OFF_STATUS);

  // Foreground address to physical byte; page picks the visible half
  function automatic logic [PHYS_W-1:0] map_phys(input logic [FG_W-1:0] a,
                                                 input logic page,
                                                 input logic mode);
    logic [PHYS_W-1:0] p;
    p = {page, a};
    if (mode) begin
      p = {page, a};
    end else begin
      p = {a[FG_W-1:2], page, a[1:0]};
    end
    return p;
  endfunction

  assign win_phys = map_phys(win_addr, eeprom_page_select, eeprom_sector_mode);
  assign cmd_addr = pwdata[CMD_ADDR_MSB:CMD_ADDR_LSB];
  assign cmd_phys = map_phys(cmd_addr, eeprom_page_select, eeprom_sector_mode);

  assign cmd_op = pwdata[CMD_OP_MSB:CMD_OP_LSB];
  assign cmd_write = wr_take && (paddr == OFF_COMMAND);
  // Unknown opcodes, busy or unloaded divider all refuse the command
  assign cmd_ok = cmd_write && load_done_flag && !busy_reg
                  && ((cmd_op == OP_PROGRAM) || (cmd_op == OP_ERASE));
  assign cmd_refused = cmd_write && !cmd_ok;

  // APB answer: data and error are prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
    end
  end

  // Read word decoded combinationally, registered in the setup cycle
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr == OFF_CLKDIV) begin
      rd_word[CD_LOAD_BIT] = load_done_flag;
      rd_word[CD_PRESCALE_BIT:0] = nvm_clock_divider_reg;
    end else if (paddr == OFF_CONFIG) begin
      rd_word[CFG_PAGE_BIT] = eeprom_page_select;
    end else if (paddr == OFF_OPTIONS) begin
      rd_word = {24'h00_0000, nvm_options_reg};
      rd_err = pwrite;
    end else if (paddr == OFF_COMMAND) begin
      rd_word[CMD_OP_MSB:CMD_OP_LSB] = op_reg;
      rd_word[CMD_ADDR_MSB:CMD_ADDR_LSB] = op_addr_reg[FG_W-1:0];
      rd_word[CMD_DATA_MSB:0] = op_data_reg;
    end else if (paddr == OFF_STATUS) begin
      rd_word[ST_BUSY_BIT] = busy_reg;
      rd_word[ST_ERR_BIT] = err_reg;
      rd_word[ST_LOAD_BIT] = load_done_flag;
    end else if (in_window) begin
      // Window is read-only; programming goes through the command register
      rd_word = {24'h00_0000, ee_mem[win_phys]};
      rd_err = pwrite;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg <= rd_word;
      pslverr_reg <= rd_err;
    end
  end

  // Load flag set by any divider write, whatever the data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_done_flag <= 1'b0;
    end else if (wr_clkdiv) begin
      load_done_flag <= 1'b1;
    end
  end

  // Only the write that sets the flag lands; no error on later ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_clock_divider_reg <= CD_RESET;
    end else if (wr_clkdiv && !load_done_flag) begin
      nvm_clock_divider_reg <= pwdata[CD_PRESCALE_BIT:0];
    end else if (wr_clkdiv) begin
      nvm_clock_divider_reg <= nvm_clock_divider_reg;
    end
  end

  // Page select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eeprom_page_select <= 1'b0;
    end else if (wr_config) begin
      eeprom_page_select <= pwdata[CFG_PAGE_BIT];
    end
  end

  // Options image taken once at the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      options_captured_reg <= 1'b0;
    end else begin
      options_captured_reg <= 1'b1;
    end
  end

  // Later changes of the image wait for the next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_options_reg <= OPT_RESET;
    end else if (!options_captured_reg) begin
      nvm_options_reg <= nv_option_image;
    end
  end

  // Sticky refusal flag; write one to clear, a new refusal wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 1'b0;
    end else if (cmd_refused) begin
      err_reg <= 1'b1;
    end else if (wr_status && pwdata[ST_ERR_BIT]) begin
      err_reg <= 1'b0;
    end
  end

  // Operation sequencer
  // Unknown opcodes are refused, so only two pulse counts are needed
  always_comb begin
    case (op_reg)
      OP_ERASE: begin
        pulse_target = ERASE_PULSES;
      end
      default: begin
        pulse_target = PROGRAM_PULSES;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      NVMCD_IDLE: begin
        if (cmd_ok) begin
          state_next = NVMCD_RUN;
        end
      end
      NVMCD_RUN: begin
        if (clk_link.tick && (pulse_cnt_reg == pulse_target - 4'h1)) begin
          state_next = NVMCD_COMMIT;
        end
      end
      NVMCD_COMMIT: begin
        state_next = NVMCD_IDLE;
      end
      default: begin
        state_next = NVMCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= NVMCD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Busy from the accepting edge through the commit cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_next != NVMCD_IDLE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_reg <= 2'h0;
      op_addr_reg <= '0;
      op_data_reg <= 8'h00;
    end else if (cmd_ok) begin
      op_reg <= cmd_op;
      op_addr_reg <= cmd_phys;
      op_data_reg <= pwdata[CMD_DATA_MSB:0];
    end
  end

  // Whole pulses only: counter starts with the divider from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_reg <= 4'h0;
    end else if (state_reg != NVMCD_RUN) begin
      pulse_cnt_reg <= 4'h0;
    end else if (clk_link.tick) begin
      pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
    end
  end

  assign clk_link.run = (state_reg == NVMCD_RUN);
  assign clk_link.prescale_by_eight = nvm_clock_divider_reg[CD_PRESCALE_BIT];
  assign clk_link.ratio = nvm_clock_divider_reg[CD_RATIO_MSB:0];

  // Sector match per byte: mode 0 sector spans both pages, mode 1 one page
  always_comb begin
    erase_hit = '0;
    for (int i = 0; i < EE_BYTES; i++) begin
      erase_hit[i] = ((i / SECTOR_BYTES) == int'(op_addr_reg / SECTOR_BYTES));
    end
  end

  // Array update; erase clears the aligned eight-byte physical sector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < EE_BYTES; i++) begin
        ee_mem[i] <= ERASED_BYTE;
      end
    end else if (state_reg == NVMCD_COMMIT) begin
      if (op_reg == OP_ERASE) begin
        for (int i = 0; i < EE_BYTES; i++) begin
          if (erase_hit[i]) begin
            ee_mem[i] <= ERASED_BYTE;
          end
        end
      end else begin
        ee_mem[op_addr_reg] <= op_data_reg;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prog_erase_enable = load_done_flag;
  assign nvm_busy = busy_reg;

endmodule

/* File: verification/nvmcd_props.sv */
// Assertion checker for the divider and paging block
`timescale 1ns/1ps
module nvmcd_props
  import nvmcd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Image and status
  input wire logic [7:0] nv_option_image,
  input wire logic prog_erase_enable,
  input wire logic nvm_busy
);
  logic seen_reg;
  logic first_reg;
  logic [6:0] div_reg;
  logic [7:0] opt_reg;
  logic [11:0] cnt_reg;
  logic [9:0] period;
  logic acc;
  assign acc = psel && penable && pready;
  assign period = 10'(div_reg[5:0] + 1) << (div_reg[6] ? 3 : 0);
  // Own copy of the first divider write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg <= 1'b0;
      div_reg <= CD_RESET;
    end else if (acc && pwrite && paddr == OFF_CLKDIV && !seen_reg) begin
      seen_reg <= 1'b1;
      div_reg <= pwdata[6:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_reg <= 1'b0;
      opt_reg <= OPT_RESET;
    end else if (!first_reg) begin
      first_reg <= 1'b1;
      opt_reg <= nv_option_image;
    end
  end
  // Busy length, judged at its fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 12'h000;
    end else begin
      cnt_reg <= nvm_busy ? cnt_reg + 12'h001 : 12'h000;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence div_write;
    acc && pwrite && paddr == OFF_CLKDIV;
  endsequence
  sequence div_read;
    acc && !pwrite && paddr == OFF_CLKDIV;
  endsequence
  sequence busy_end;
    $fell(nvm_busy);
  endsequence
  enable_set_a: assert property (div_write |=> prog_erase_enable)
    else $error("load flag not set by divider write");
  enable_sticky_a: assert property (prog_erase_enable |=> prog_erase_enable)
    else $error("load flag dropped without reset");
  flag_readback_a: assert property (div_read |-> prdata[7] == prog_erase_enable)
    else $error("divider bit 7 differs from load flag");
  div_value_a: assert property (div_read |-> prdata[6:0] == div_reg)
    else $error("divider readback not first written value");
  options_read_a: assert property (acc && !pwrite && paddr == OFF_OPTIONS && first_reg
    |-> prdata[7:0] == opt_reg)
    else $error("options differ from reset image");
  options_write_a: assert property (acc && pwrite && paddr == OFF_OPTIONS |-> pslverr)
    else $error("options write not refused");
  busy_gate_a: assert property ($rose(nvm_busy) |-> prog_erase_enable)
    else $error("operation started before divider load");
  pulse_count_a: assert property (busy_end |-> cnt_reg >= 2 * period
    && cnt_reg <= 4 * period + 3 && cnt_reg % period <= 3)
    else $error("busy length not whole timing pulses");
endmodule

/* File: verification/nvmcd_cpu_model.sv */
// Bus master model standing in for the CPU core
`timescale 1ns/1ps
module nvmcd_cpu_model (
  // Clock
  input wire logic pclk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the divider and paging block
`timescale 1ns/1ps
module tb;
  import nvmcd_pkg::*;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] v; logic e;} nvmcd_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, prog_erase_enable, nvm_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] nv_option_image;
  logic er;
  int fails, check_count, cycles, n, k;
  nvmcd_row_type rows [0:34];
  nvmcd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nv_option_image(nv_option_image),
    .prog_erase_enable(prog_erase_enable), .nvm_busy(nvm_busy));
  nvmcd_cpu_model i_cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Writes wait out any operation they start
  task automatic run_rows(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      i_cpu.xfer(rows[i].w, rows[i].a, rows[i].v, rd, er);
      check({31'h0, er}, {31'h0, rows[i].e});
      if (rows[i].w) begin
        repeat (2) @(negedge pclk);
        while (nvm_busy !== 1'b0) @(negedge pclk);
      end else begin
        check(rd, rows[i].v);
      end
    end
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    rows = '{
      '{1'h0, 12'h000, 32'h00, 1'h0}, '{1'h1, 12'h00C, 32'h103A5, 1'h0},
      '{1'h0, 12'h010, 32'h02, 1'h0}, '{1'h0, 12'h10C, 32'hFF, 1'h0},
      '{1'h1, 12'h000, 32'h50, 1'h0}, '{1'h0, 12'h000, 32'hD0, 1'h0},
      '{1'h1, 12'h000, 32'h3F, 1'h0}, '{1'h0, 12'h000, 32'hD0, 1'h0},
      '{1'h0, 12'h010, 32'h82, 1'h0}, '{1'h0, 12'h008, 32'h20, 1'h0},
      '{1'h1, 12'h008, 32'h00, 1'h1}, '{1'h1, 12'h00C, 32'h103A5, 1'h0},
      '{1'h0, 12'h10C, 32'hA5, 1'h0}, '{1'h1, 12'h004, 32'h40, 1'h0},
      '{1'h0, 12'h10C, 32'hFF, 1'h0}, '{1'h1, 12'h00C, 32'h1035A, 1'h0},
      '{1'h0, 12'h10C, 32'h5A, 1'h0}, '{1'h1, 12'h00C, 32'h20000, 1'h0},
      '{1'h0, 12'h10C, 32'hFF, 1'h0}, '{1'h1, 12'h004, 32'h00, 1'h0},
      '{1'h0, 12'h10C, 32'hA5, 1'h0}, '{1'h0, 12'h020, 32'h00, 1'h1},
      '{1'h0, 12'h000, 32'h00, 1'h0}, '{1'h0, 12'h008, 32'h00, 1'h0},
      '{1'h1, 12'h000, 32'h50, 1'h0}, '{1'h1, 12'h00C, 32'h10111, 1'h0},
      '{1'h1, 12'h004, 32'h40, 1'h0}, '{1'h1, 12'h00C, 32'h10122, 1'h0},
      '{1'h0, 12'h104, 32'h22, 1'h0}, '{1'h1, 12'h004, 32'h00, 1'h0},
      '{1'h0, 12'h104, 32'h11, 1'h0}, '{1'h1, 12'h00C, 32'h20100, 1'h0},
      '{1'h0, 12'h104, 32'hFF, 1'h0}, '{1'h1, 12'h004, 32'h40, 1'h0},
      '{1'h0, 12'h104, 32'hFF, 1'h0}};
    presetn = 1'b0;
    nv_option_image = 8'h20;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    run_rows(0, 21);
    $display("test rows in sector mode 1 done");
    // Prescale on, ratio 16: pulse is 136 bus cycles
    for (k = 0; k < 2; k++) begin
      i_cpu.xfer(1'b1, OFF_COMMAND, k ? 32'h20800 : 32'h10800, rd, er);
      n = 0;
      repeat (2) @(negedge pclk);
      while (nvm_busy === 1'b1) begin
        n++;
        @(negedge pclk);
      end
      check(32'(n >= (2 + 2 * k) * 136 && n <= (2 + 2 * k) * 136 + 3), 32'h1);
    end
    $display("test pulse timing done");
    // Flag clearing, refused commands, window write and readback
    i_cpu.xfer(1'b1, OFF_STATUS, 32'h02, rd, er);
    i_cpu.xfer(1'b0, OFF_STATUS, 32'h0, rd, er);
    check(rd, 32'h80);
    i_cpu.xfer(1'b1, OFF_COMMAND, 32'h30000, rd, er);
    i_cpu.xfer(1'b0, OFF_STATUS, 32'h0, rd, er);
    check(rd, 32'h82);
    i_cpu.xfer(1'b1, OFF_STATUS, 32'h02, rd, er);
    i_cpu.xfer(1'b1, OFF_COMMAND, 32'h10500, rd, er);
    i_cpu.xfer(1'b1, OFF_COMMAND, 32'h10655, rd, er);
    i_cpu.xfer(1'b0, OFF_STATUS, 32'h0, rd, er);
    check(rd, 32'h83);
    while (nvm_busy !== 1'b0) @(negedge pclk);
    i_cpu.xfer(1'b0, OFF_COMMAND, 32'h0, rd, er);
    check(rd, 32'h10500);
    i_cpu.xfer(1'b0, 12'h114, 32'h0, rd, er);
    check(rd, 32'h00);
    i_cpu.xfer(1'b0, 12'h118, 32'h0, rd, er);
    check(rd, 32'hFF);
    i_cpu.xfer(1'b1, OFF_CONFIG, 32'hFF, rd, er);
    i_cpu.xfer(1'b0, OFF_CONFIG, 32'h0, rd, er);
    check(rd, 32'h40);
    i_cpu.xfer(1'b1, OFF_CONFIG, 32'h0, rd, er);
    i_cpu.xfer(1'b1, 12'h118, 32'h12, rd, er);
    check({31'h0, er}, 32'h1);
    i_cpu.xfer(1'b0, 12'h118, 32'h0, rd, er);
    check(rd, 32'hFF);
    $display("test refusals and readback done");
    // Reset lands in mid-operation
    i_cpu.xfer(1'b1, OFF_COMMAND, 32'h10000, rd, er);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    nv_option_image <= 8'h00;
    repeat (10) @(posedge pclk);
    check({30'h0, nvm_busy, prog_erase_enable}, 32'h0);
    presetn <= 1'b1;
    run_rows(22, 34);
    $display("test reset and sector mode 0 done");
    final_report();
  end
endmodule
bind nvmcd_top nvmcd_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .nv_option_image(nv_option_image),
  .prog_erase_enable(prog_erase_enable), .nvm_busy(nvm_busy));
